// >>> common/crs_defs.svh
// Stream format and timing constants of the configuration readback shifter
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// Stream layout
`define CRS_LEAD_BITS 5
`define CRS_CHECK_BITS 4
`define CRS_TAIL_ONES 7
`define CRS_FORCED_ONES 2
`define CRS_RAM_BITS 2
`define CRS_LOAD_WIN 6

// Signature generator
`define CRS_CRC_BITS 11
`define CRS_CRC_POLY 11'h385
`define CRS_CRC_INIT 11'h000

// Link clock made by the controller, from the 10 ns reference clock
`define CRS_REF_PERIOD_NS 10
`define CRS_LINK_HALF_NS 40
`define CRS_LINK_HALF_CYC ((`CRS_LINK_HALF_NS + `CRS_REF_PERIOD_NS - 1) / `CRS_REF_PERIOD_NS)

// Synchroniser delay seen by the device on the trigger, in link clocks
`define CRS_SYNC_EDGES 2

`endif

// >>> common/crs_pkg.sv
// Types shared by both ends of the configuration readback link
package crs_pkg;

    // Device sequencer states
    typedef enum logic [6:0] {
        CRS_D_IDLE   = 7'h01,
        CRS_D_LEAD   = 7'h02,
        CRS_D_FRAME  = 7'h04,
        CRS_D_TSTART = 7'h08,
        CRS_D_CRC    = 7'h10,
        CRS_D_HOLD   = 7'h20,
        CRS_D_REARM  = 7'h40
    } crs_dev_state_t;

    // Controller sequencer states
    typedef enum logic [3:0] {
        CRS_C_IDLE  = 4'h1,
        CRS_C_WAIT  = 4'h2,
        CRS_C_RUN   = 4'h4,
        CRS_C_DRAIN = 4'h8
    } crs_ctl_state_t;

endpackage : crs_pkg

// >>> common/crs_link_if.sv
// Four readback nets joining the array and its external controller
interface crs_link_if;
    logic readback_trigger;
    logic readback_clock_in;
    logic readback_serial_out;
    logic read_in_progress;

    // Array end
    modport device (
        input readback_trigger,
        input readback_clock_in,
        output readback_serial_out,
        output read_in_progress
    );

    // Controller end
    modport controller (
        output readback_trigger,
        output readback_clock_in,
        input readback_serial_out,
        input read_in_progress
    );
endinterface : crs_link_if

// >>> hw/crs_frame_cnt.sv
// Bit-in-frame and frame counter used by both ends to track stream position
module crs_frame_cnt
    import crs_pkg::*;
#(
    parameter int LEN = 21,
    parameter int FRAMES = 4,
    localparam int PW = (LEN > 1) ? $clog2(LEN) : 1,
    localparam int FW = (FRAMES > 1) ? $clog2(FRAMES) : 1
) (
    // Clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic step,
    // Position
    output logic [PW-1:0] bit_pos,
    output logic [FW-1:0] frame,
    output logic last_bit,
    output logic last_frame
);

    // End markers
    assign last_bit = (bit_pos == PW'(LEN - 1));
    assign last_frame = (frame == FW'(FRAMES - 1));

    // Advance one bit per step, wrapping frames
    always_ff @(posedge clk) begin
        if (reset || clear) begin
            bit_pos <= '0;
            frame <= '0;
        end else if (step) begin
            if (last_bit) begin
                bit_pos <= '0;
                frame <= last_frame ? '0 : frame + 1'b1;
            end else begin
                bit_pos <= bit_pos + 1'b1;
            end
        end
    end

endmodule : crs_frame_cnt

// >>> hw/crs_device.sv
// Array end: shifts configuration memory and captured state out on the link
`include "crs_defs.svh"

// Behaviour
// RQ1: Readback runs beside user logic, never disturbing it
// RQ2: Stream can carry flip-flop, latch and RAM state
// RQ3: Trigger high after configuration raises in-progress flag
// RQ4: Each later rising edge presents next bit
// RQ5: No preamble; five ones then start zero
// RQ6: First two data bits of frame zero are one
// RQ7: Four check positions per frame read as one
// RQ8: Last seven positions of last frame are one
// RQ9: Extra start zero, 11-bit signature, then flag drops
// RQ10: Trigger rise latches inverted node state when capturing
// RQ11: Without capture, capture positions show loaded configuration
// RQ12: Live RAM contents replace two function-table bits
// RQ13: With abort, trigger fall ends readback and re-arms
// RQ14: Controller gives extra clocks after abort for re-init
// RQ15: Everything clocked on rising edges of selected clock
// RQ16: Capture, abort and clock options fixed at build
// RQ17: Unbound control nets make readback impossible
// RQ18: Next frame loaded in six clocks before start
// RQ19: Controller keeps clock running near every start bit
// RQ20: Controller tracks frame position, never stalls near boundaries
// RQ21: Trigger ignored until configuration reached its finish
// RQ22: Frame count and length are design parameters
module crs_device
    import crs_pkg::*;
#(
    parameter int FRAMES = 4,
    parameter int DATA_BITS = 16,
    parameter int CAP_W = 4,
    // RQ16 build-time options
    parameter bit CAPTURE_EN = 1'b1,
    parameter bit RAM_EN = 1'b0,
    parameter bit ABORT_EN = 1'b1,
    parameter bit LINK_BOUND = 1'b1,
    localparam int LEN = 1 + DATA_BITS + `CRS_CHECK_BITS,
    localparam int PW = (LEN > 1) ? $clog2(LEN) : 1,
    localparam int FW = (FRAMES > 1) ? $clog2(FRAMES) : 1
) (
    // Link; its clock is the selected readback clock
    crs_link_if.device link,
    // Reset, synchronous to the link clock
    input wire logic reset,
    // Configuration load port, on the link clock
    input wire logic cfg_write,
    input wire logic [FW-1:0] cfg_frame,
    input wire logic [DATA_BITS-1:0] cfg_word,
    // User logic levels, from other clock domains
    input wire logic config_done,
    input wire logic [FRAMES*CAP_W-1:0] node_state,
    input wire logic [FRAMES*`CRS_RAM_BITS-1:0] ram_state
);

    crs_dev_state_t state;
    logic trig_s1, trig_s2, trig_prev;
    logic done_s1, done_s2;
    logic [FRAMES*CAP_W-1:0] node_s1, node_s2, cap;
    logic [FRAMES*`CRS_RAM_BITS-1:0] ram_s1, ram_s2;
    logic [DATA_BITS-1:0] mem [FRAMES];
    logic [DATA_BITS-1:0] hold, sr;
    logic [`CRS_CRC_BITS-1:0] crc;
    logic [2:0] lead_cnt;
    logic [3:0] crc_cnt;
    logic [15:0] rearm_cnt;
    logic trig_on, trig_rise, trig_fall, in_data, running, next_sdo;
    logic [PW-1:0] bit_pos;
    logic [FW-1:0] frame_idx;
    logic last_bit, last_frame;

    // Two-flop synchronisers for everything from outside the link domain;
    // node and RAM vectors are quasi-static while sampled, so per-bit sync is enough
    always_ff @(posedge link.readback_clock_in) begin
        trig_s1 <= link.readback_trigger;
        trig_s2 <= trig_s1;
        done_s1 <= config_done;
        done_s2 <= done_s1;
        node_s1 <= node_state;
        node_s2 <= node_s1;
        ram_s1 <= ram_state;
        ram_s2 <= ram_s1;
    end

    // RQ17 unbound nets lock out
    assign trig_on = LINK_BOUND && trig_s2;
    assign trig_rise = trig_on && !trig_prev;
    assign trig_fall = !trig_on && trig_prev;
    assign running = (state == CRS_D_LEAD) || (state == CRS_D_FRAME)
        || (state == CRS_D_TSTART) || (state == CRS_D_CRC);
    assign in_data = (state == CRS_D_FRAME) && (bit_pos != '0)
        && (bit_pos <= PW'(DATA_BITS));

    // Trigger edge history
    always_ff @(posedge link.readback_clock_in) begin
        if (reset) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_on;
        end
    end

    // Configuration memory, written only by the load port, never by readback
    always_ff @(posedge link.readback_clock_in) begin
        if (cfg_write) begin
            mem[cfg_frame] <= cfg_word;
        end
    end

    // RQ10 inverted capture on trigger rise
    always_ff @(posedge link.readback_clock_in) begin
        if (reset) begin
            cap <= '0;
        end else if (CAPTURE_EN && trig_rise && state == CRS_D_IDLE) begin
            cap <= ~node_s2;
        end
    end

    // Builds one frame word from memory, capture and RAM
    function automatic logic [DATA_BITS-1:0] frame_word(input logic [FW-1:0] f);
        logic [DATA_BITS-1:0] w;
        w = mem[f];
        // RQ2 state in stream
        // RQ11 configuration kept without capture
        if (CAPTURE_EN) begin
            w[CAP_W-1:0] = cap[f*CAP_W +: CAP_W];
        end
        // RQ12 live RAM bits
        if (RAM_EN) begin
            w[CAP_W +: `CRS_RAM_BITS] = ram_s2[f*`CRS_RAM_BITS +: `CRS_RAM_BITS];
        end
        // RQ6 first two bits high
        if (f == '0) begin
            w[DATA_BITS-1 -: `CRS_FORCED_ONES] = '1;
        end
        return w;
    endfunction : frame_word

    // RQ22 parameterised frame position
    crs_frame_cnt #(
        .LEN(LEN),
        .FRAMES(FRAMES)
    ) u_pos (
        .clk(link.readback_clock_in),
        .reset(reset),
        .clear(state != CRS_D_FRAME),
        .step(state == CRS_D_FRAME),
        .bit_pos(bit_pos),
        .frame(frame_idx),
        .last_bit(last_bit),
        .last_frame(last_frame)
    );

    // Next serial bit from the position in the stream
    always_comb begin
        next_sdo = 1'b1;
        case (state)
            CRS_D_FRAME: begin
                // RQ5 start bit low
                if (bit_pos == '0) begin
                    next_sdo = 1'b0;
                // RQ8 trailing ones
                end else if (last_frame && bit_pos >= PW'(LEN - `CRS_TAIL_ONES)) begin
                    next_sdo = 1'b1;
                end else if (in_data) begin
                    next_sdo = sr[DATA_BITS-1];
                // RQ7 check bits high
                end else begin
                    next_sdo = 1'b1;
                end
            end
            CRS_D_TSTART: begin
                next_sdo = 1'b0;
            end
            CRS_D_CRC: begin
                next_sdo = (crc_cnt < 4'(`CRS_CRC_BITS)) ? crc[`CRS_CRC_BITS-1] : 1'b1;
            end
            default: begin
                next_sdo = 1'b1;
            end
        endcase
    end

    // RQ18 load next frame during last six clocks; only the hold word moves,
    // the shift register itself keeps shifting and takes the hold word only at start bits
    always_ff @(posedge link.readback_clock_in) begin
        if (reset) begin
            hold <= '0;
        end else if (state == CRS_D_LEAD
                && lead_cnt == 3'(`CRS_LEAD_BITS - `CRS_LOAD_WIN + 1)) begin
            hold <= frame_word('0);
        end else if (state == CRS_D_FRAME && !last_frame
                && bit_pos == PW'(LEN - `CRS_LOAD_WIN)) begin
            hold <= frame_word(frame_idx + 1'b1);
        end
    end

    // Output shift register, taken over at each start bit
    always_ff @(posedge link.readback_clock_in) begin
        if (reset) begin
            sr <= '0;
        end else if (state == CRS_D_FRAME && bit_pos == '0) begin
            sr <= hold;
        end else if (in_data) begin
            sr <= {sr[DATA_BITS-2:0], 1'b0};
        end
    end

    // Signature over the data bits as sent, then shifted out MSB first
    always_ff @(posedge link.readback_clock_in) begin
        if (reset || state == CRS_D_IDLE) begin
            crc <= `CRS_CRC_INIT;
        end else if (in_data) begin
            crc <= {crc[`CRS_CRC_BITS-2:0], 1'b0}
                ^ ((crc[`CRS_CRC_BITS-1] ^ next_sdo) ? `CRS_CRC_POLY : '0);
        end else if (state == CRS_D_CRC) begin
            crc <= {crc[`CRS_CRC_BITS-2:0], 1'b0};
        end
    end

    // RQ4 one bit per rising edge
    // RQ15 rising edges of link clock
    always_ff @(posedge link.readback_clock_in) begin
        if (reset) begin
            link.readback_serial_out <= 1'b1;
        end else begin
            link.readback_serial_out <= next_sdo;
        end
    end

    // Sequencer; RQ1 it only reads memory and node levels, so user logic runs on
    always_ff @(posedge link.readback_clock_in) begin
        if (reset) begin
            state <= CRS_D_IDLE;
            link.read_in_progress <= 1'b0;
            lead_cnt <= '0;
            crc_cnt <= '0;
            rearm_cnt <= '0;
        // RQ13 abort on trigger fall
        end else if (ABORT_EN && running && trig_fall) begin
            state <= CRS_D_REARM;
            link.read_in_progress <= 1'b0;
            rearm_cnt <= '0;
        end else begin
            case (state)
                CRS_D_IDLE: begin
                    // RQ21 need finished configuration
                    // RQ3 flag rises on next edge
                    if (trig_on && done_s2) begin
                        state <= CRS_D_LEAD;
                        link.read_in_progress <= 1'b1;
                        lead_cnt <= '0;
                    end
                end
                CRS_D_LEAD: begin
                    // RQ5 five leading ones
                    lead_cnt <= lead_cnt + 1'b1;
                    if (lead_cnt == 3'(`CRS_LEAD_BITS - 1)) begin
                        state <= CRS_D_FRAME;
                    end
                end
                CRS_D_FRAME: begin
                    if (last_bit && last_frame) begin
                        state <= CRS_D_TSTART;
                    end
                end
                CRS_D_TSTART: begin
                    state <= CRS_D_CRC;
                    crc_cnt <= '0;
                end
                CRS_D_CRC: begin
                    // RQ9 flag drops after signature
                    crc_cnt <= crc_cnt + 1'b1;
                    if (crc_cnt == 4'(`CRS_CRC_BITS)) begin
                        state <= CRS_D_HOLD;
                        link.read_in_progress <= 1'b0;
                    end
                end
                CRS_D_HOLD: begin
                    // A held trigger must be released before the next readback
                    if (!trig_on) begin
                        state <= CRS_D_IDLE;
                    end
                end
                CRS_D_REARM: begin
                    // RQ14 re-init needs extra clocks
                    rearm_cnt <= rearm_cnt + 1'b1;
                    if (rearm_cnt == 16'(FRAMES - 1)) begin
                        state <= CRS_D_IDLE;
                    end
                end
                default: begin
                    state <= CRS_D_IDLE;
                end
            endcase
        end
    end

endmodule : crs_device

// >>> hw/crs_controller.sv
// Controller end: makes the link clock, triggers readback, collects the bits
`include "crs_defs.svh"

module crs_controller
    import crs_pkg::*;
#(
    parameter int FRAMES = 4,
    parameter int DATA_BITS = 16,
    localparam int LEN = 1 + DATA_BITS + `CRS_CHECK_BITS,
    localparam int PW = (LEN > 1) ? $clog2(LEN) : 1,
    localparam int FW = (FRAMES > 1) ? $clog2(FRAMES) : 1,
    localparam int HALF = `CRS_LINK_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Link
    crs_link_if.controller link,
    // User requests
    input wire logic rb_start,
    input wire logic rb_abort,
    // User results
    output logic rb_busy,
    output logic rb_bit_valid,
    output logic rb_bit_data,
    output logic rb_in_frame,
    output logic [FW-1:0] rb_frame,
    output logic [PW-1:0] rb_bit_pos
);

    crs_ctl_state_t state;
    logic [7:0] div;
    logic rip_s1, rip_s2, dat_s1, dat_s2;
    logic sample;
    logic [2:0] lead_cnt;
    logic [15:0] drain_cnt;
    logic tail;
    logic [PW-1:0] bit_pos;
    logic [FW-1:0] frame;
    logic last_bit, last_frame;

    // RQ19 free-running link clock never pauses
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div <= '0;
            link.readback_clock_in <= 1'b0;
        end else if (div == 8'(HALF - 1)) begin
            div <= '0;
            link.readback_clock_in <= !link.readback_clock_in;
        end else begin
            div <= div + 1'b1;
        end
    end

    // Sample just before the next rising edge, long after the synchronisers settled
    assign sample = !link.readback_clock_in && (div == 8'(HALF - 1));

    // Two-flop synchronisers for the device outputs
    always_ff @(posedge ref_clk) begin
        rip_s1 <= link.read_in_progress;
        rip_s2 <= rip_s1;
        dat_s1 <= link.readback_serial_out;
        dat_s2 <= dat_s1;
    end

    // RQ20 track position within frames
    crs_frame_cnt #(
        .LEN(LEN),
        .FRAMES(FRAMES)
    ) u_pos (
        .clk(ref_clk),
        .reset(reset),
        .clear(state != CRS_C_RUN),
        .step(sample && state == CRS_C_RUN && rip_s2 && !tail
            && lead_cnt == 3'(`CRS_LEAD_BITS)),
        .bit_pos(bit_pos),
        .frame(frame),
        .last_bit(last_bit),
        .last_frame(last_frame)
    );

    // Sequencer and reported bits
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= CRS_C_IDLE;
            link.readback_trigger <= 1'b0;
            rb_busy <= 1'b0;
            rb_bit_valid <= 1'b0;
            rb_bit_data <= 1'b0;
            rb_in_frame <= 1'b0;
            rb_frame <= '0;
            rb_bit_pos <= '0;
            lead_cnt <= '0;
            drain_cnt <= '0;
            tail <= 1'b0;
        end else begin
            rb_bit_valid <= 1'b0;
            case (state)
                CRS_C_IDLE: begin
                    // RQ3 hold trigger high
                    if (rb_start) begin
                        link.readback_trigger <= 1'b1;
                        rb_busy <= 1'b1;
                        state <= CRS_C_WAIT;
                    end
                end
                CRS_C_WAIT: begin
                    if (rb_abort) begin
                        link.readback_trigger <= 1'b0;
                        drain_cnt <= '0;
                        state <= CRS_C_DRAIN;
                    end else if (sample && rip_s2) begin
                        lead_cnt <= '0;
                        tail <= 1'b0;
                        state <= CRS_C_RUN;
                    end
                end
                CRS_C_RUN: begin
                    if (rb_abort || (sample && !rip_s2)) begin
                        link.readback_trigger <= 1'b0;
                        drain_cnt <= '0;
                        state <= CRS_C_DRAIN;
                    end else if (sample) begin
                        rb_bit_valid <= 1'b1;
                        rb_bit_data <= dat_s2;
                        rb_frame <= frame;
                        rb_bit_pos <= bit_pos;
                        rb_in_frame <= !tail && lead_cnt == 3'(`CRS_LEAD_BITS);
                        if (lead_cnt != 3'(`CRS_LEAD_BITS)) begin
                            lead_cnt <= lead_cnt + 1'b1;
                        end else if (last_bit && last_frame) begin
                            tail <= 1'b1;
                        end
                    end
                end
                CRS_C_DRAIN: begin
                    // RQ14 one clock per frame, plus trigger sync
                    if (sample) begin
                        drain_cnt <= drain_cnt + 1'b1;
                        if (drain_cnt == 16'(FRAMES + `CRS_SYNC_EDGES)) begin
                            rb_busy <= 1'b0;
                            state <= CRS_C_IDLE;
                        end
                    end
                end
                default: begin
                    state <= CRS_C_IDLE;
                end
            endcase
        end
    end

endmodule : crs_controller

// >>> tb/crs_link_assertions.sv
// Checker for stream layout and flag timing on the link nets
module crs_link_assertions #(
    parameter int FRAMES = 4,
    parameter int DATA_BITS = 16
) (
    // Link domain clock and reset
    input wire logic readback_clock_in,
    input wire logic reset,
    input wire logic config_done,
    // Link nets
    input wire logic readback_trigger,
    input wire logic readback_serial_out,
    input wire logic read_in_progress
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LEN = DATA_BITS + 5;
    localparam int TAIL = 6 + LEN * FRAMES;
    int cnt;

    default clocking cb @(posedge readback_clock_in);
    endclocking
    default disable iff (reset);

    // Bit index since the flag rose; cleared while idle so aborts restart it
    always_ff @(posedge readback_clock_in) begin
        if (reset || !read_in_progress) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end

    rip_rise_a: assert property (
        $rose(readback_trigger) && config_done |-> ##[1:4] read_in_progress)
        else $error("flag did not rise after trigger");
    need_done_a: assert property (
        $rose(read_in_progress) |-> $past(readback_trigger, 2) && $past(config_done, 2))
        else $error("flag rose without trigger or finished configuration");
    lead_ones_a: assert property (
        $rose(read_in_progress) |-> readback_serial_out [*6] ##1 !readback_serial_out)
        else $error("lead ones or first start bit wrong");
    first_data_a: assert property (
        $rose(read_in_progress) |-> ##7 readback_serial_out [*2])
        else $error("first two data bits not high");
    start_zero_a: assert property (
        read_in_progress && cnt >= 6 && cnt < TAIL && (cnt - 6) % LEN == 0
        |-> !readback_serial_out)
        else $error("frame start bit not low");
    check_ones_a: assert property (
        read_in_progress && cnt >= 6 && cnt < TAIL && (cnt - 6) % LEN >= LEN - 4
        |-> readback_serial_out)
        else $error("check bit not high");
    tail_ones_a: assert property (
        read_in_progress && cnt >= TAIL - 7 && cnt < TAIL |-> readback_serial_out)
        else $error("last frame tail not high");
    crc_end_a: assert property (
        read_in_progress && cnt == TAIL |-> !readback_serial_out ##12 !read_in_progress)
        else $error("extra start or flag drop misplaced");
    hold_flag_a: assert property (
        readback_trigger [*3] ##0 (read_in_progress && cnt < TAIL + 11) |=> read_in_progress)
        else $error("flag dropped before signature end");
    abort_drop_a: assert property (
        read_in_progress && $fell(readback_trigger) |-> ##[1:4] !read_in_progress)
        else $error("trigger fall did not end readback");
    idle_high_a: assert property (
        !read_in_progress && !$past(read_in_progress) |-> readback_serial_out)
        else $error("serial line not high while idle");

    // Main scenarios: start, abort, full stream
    cover property ($rose(read_in_progress));
    cover property (read_in_progress && $fell(readback_trigger));
    cover property (read_in_progress && cnt == TAIL);
endmodule : crs_link_assertions

// >>> tb/crs_link_tb.sv
// Testbench joining controller and array ends over the readback link
`include "crs_defs.svh"

module crs_link_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FRAMES = 4;
    localparam int DATA_BITS = 16;
    localparam int CAP_W = 4;
    localparam int LEN = DATA_BITS + 5;
    localparam int NBITS = 5 + FRAMES * LEN + 12;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic dev_reset = 1'b1;
    logic cfg_write = 1'b0;
    logic [1:0] cfg_frame = 2'h0;
    logic [DATA_BITS-1:0] cfg_word = 16'h0000;
    logic config_done = 1'b0;
    logic [FRAMES*CAP_W-1:0] node_state = 16'hA5C3;
    logic [FRAMES*2-1:0] ram_state = 8'h6C;
    logic rb_start = 1'b0;
    logic rb_abort = 1'b0;
    logic rb_busy, rb_bit_valid, rb_bit_data, rb_in_frame;
    logic [1:0] rb_frame;
    logic [4:0] rb_bit_pos;
    logic [DATA_BITS-1:0] mem [FRAMES];
    logic exp_q [$];
    logic [8:0] got [$];
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    crs_link_if link ();
    crs_controller #(.FRAMES(FRAMES), .DATA_BITS(DATA_BITS)) u_crs_controller (
        .ref_clk(ref_clk), .reset(reset), .link(link.controller),
        .rb_start(rb_start), .rb_abort(rb_abort), .rb_busy(rb_busy),
        .rb_bit_valid(rb_bit_valid), .rb_bit_data(rb_bit_data),
        .rb_in_frame(rb_in_frame), .rb_frame(rb_frame), .rb_bit_pos(rb_bit_pos));
    crs_device #(.FRAMES(FRAMES), .DATA_BITS(DATA_BITS), .CAP_W(CAP_W), .RAM_EN(1'b1))
    u_crs_device (
        .link(link.device), .reset(dev_reset), .cfg_write(cfg_write),
        .cfg_frame(cfg_frame), .cfg_word(cfg_word), .config_done(config_done),
        .node_state(node_state), .ram_state(ram_state));
    crs_link_assertions #(.FRAMES(FRAMES), .DATA_BITS(DATA_BITS)) u_crs_link_assertions (
        .readback_clock_in(link.readback_clock_in), .reset(dev_reset),
        .config_done(config_done), .readback_trigger(link.readback_trigger),
        .readback_serial_out(link.readback_serial_out),
        .read_in_progress(link.read_in_progress));

    // Reference clock, 100 MHz
    always #5 ref_clk = ~ref_clk;

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checked++;
        if (exp !== seen) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Expected stream, built bit by bit
    task automatic make_expected();
        logic [DATA_BITS-1:0] w;
        logic [10:0] crc;
        int n;
        exp_q = {};
        repeat (5) exp_q.push_back(1'b1);
        for (int f = 0; f < FRAMES; f++) begin
            w = mem[f];
            w[CAP_W-1:0] = ~node_state[f*CAP_W +: CAP_W];
            w[CAP_W +: 2] = ram_state[f*2 +: 2];
            if (f == 0) w[DATA_BITS-1 -: 2] = 2'b11;
            exp_q.push_back(1'b0);
            for (int b = DATA_BITS - 1; b >= 0; b--) exp_q.push_back(w[b]);
            repeat (4) exp_q.push_back(1'b1);
        end
        n = exp_q.size();
        for (int i = n - 7; i < n; i++) exp_q[i] = 1'b1;
        crc = `CRS_CRC_INIT;
        for (int i = 5; i < n; i++) begin
            if ((i - 5) % LEN != 0 && (i - 5) % LEN <= DATA_BITS) begin
                crc = {crc[9:0], 1'b0} ^ ((crc[10] ^ exp_q[i]) ? `CRS_CRC_POLY : 11'h000);
            end
        end
        exp_q.push_back(1'b0);
        for (int b = 10; b >= 0; b--) exp_q.push_back(crc[b]);
    endtask : make_expected

    // Loads all frames; memory has no reset
    task automatic load_mem();
        for (int f = 0; f < FRAMES; f++) begin
            @(posedge link.readback_clock_in);
            #1;
            cfg_write = 1'b1;
            cfg_frame = f[1:0];
            cfg_word = mem[f];
        end
        @(posedge link.readback_clock_in);
        #1;
        cfg_write = 1'b0;
    endtask : load_mem

    // One readback; nodes change mid-run so a late capture shows up
    task automatic run_read(input int abort_cyc, input bit live);
        make_expected();
        got = {};
        rb_start = 1'b1;
        @(posedge ref_clk);
        #1;
        rb_start = 1'b0;
        check("busy", 16'h1, {15'h0, rb_busy});
        for (int c = 1; c < 3000 && rb_busy === 1'b1; c++) begin
            rb_abort = (c == abort_cyc);
            if (c == 150) node_state = ~node_state;
            @(posedge ref_clk);
            #1;
            if (rb_bit_valid === 1'b1)
                got.push_back({rb_in_frame, 7'(rb_frame * LEN + rb_bit_pos), rb_bit_data});
        end
        rb_abort = 1'b0;
        if (abort_cyc == 0) check("length", 16'(NBITS), 16'(got.size()));
        else if (!live) check("length", 16'h0, 16'(got.size()));
        else check("cut short", 16'h1, 16'(got.size() < 60));
        for (int i = 0; i < got.size() && i < NBITS; i++) begin
            check("stream bit", {15'h0, exp_q[i]}, {15'h0, got[i][0]});
            check("pos", (i < 5 || i >= NBITS - 12) ? 16'h0 : 16'(128 + i - 5),
                {8'h0, got[i][8:1]});
        end
        check("flag idle", 16'h0, {14'h0, rb_busy, link.read_in_progress});
    endtask : run_read

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Main sequence: refused, two full runs, abort, re-armed run
    initial begin
        for (int f = 0; f < FRAMES; f++) mem[f] = 16'h5A3C ^ 16'(16'h0F1E << f);
        repeat (2) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        repeat (5) @(posedge link.readback_clock_in);
        #1;
        dev_reset = 1'b0;
        load_mem();
        run_read(200, 1'b0);
        config_done = 1'b1;
        repeat (4) @(posedge link.readback_clock_in);
        @(posedge ref_clk);
        #1;
        run_read(0, 1'b1);
        run_read(0, 1'b1);
        run_read(300, 1'b1);
        run_read(0, 1'b1);
        end_of_test();
    end
endmodule : crs_link_tb
